// [design/analog_fault_regs.sv]
// Operation
// - Fault flags at 0x15, reset reads 0x150000
// - Writing 1 clears or refreshes a flag
// - Disabled diagnostic flags always read zero
// - Bit 21 shows inverted alarm pin level
// - Bits 20:16 return the register address
// - Bit 13: output pin outside supply band
// - Bit 11: positive converter short circuit
// - Bit 9: positive converter cannot regulate
// - Bit 7: current open or no headroom
// - Bit 6: voltage output short circuit
// - Bit 5: converter die overtemperature
// - Bit 4: main die overtemperature
// - Bit 3: reference output window or limit
// - Bit 2: reference input out of window
// - Bit 1: internal analog supply out of window
// - Bit 0: regulator node window or limit
// - Combined status at 0x16, reset 0x100000
// - Status carries converter, watchdog, summaries, alarm
// - Status bit 19 ORs flag bits 13:0
`timescale 1ns/1ps
`default_nettype none

module analog_fault_regs (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Register access from the device core
	input wire fault_regs_pkg::reg_req_s req_in,
	output var fault_regs_pkg::reg_resp_s resp_out,
	// Fault detectors and their enables
	input wire fault_regs_pkg::fault_cond_s cond_in,
	input wire fault_regs_pkg::flag_vec_t diag_enable_in,
	// Pin and neighbouring status
	input wire logic alarm_pin_n_in,
	input wire fault_regs_pkg::adc_status_s adc_status_in,
	input wire logic digital_fault_summary_in,
	// Status towards the device core
	output var logic analog_fault_summary_out,
	output var logic ro_write_out
);
	import fault_regs_pkg::*;

	flag_vec_t events;
	flag_vec_t clear_vec;
	flag_vec_t flags_raw;
	flag_vec_t visible;
	word_t flags_word;
	word_t status_word;
	logic wr_flags;
	logic wr_status;
	logic rd_flags;
	logic rd_status;
	reg_resp_s resp_r;
	reg_resp_s resp_nxt;
	logic summary_r;
	logic summary_nxt;
	logic ro_write_r;
	logic ro_write_nxt;

	// One compare for every strobe and address pair
	function automatic logic strobe_at(input logic strobe, input logic [4:0] addr, input logic [4:0] target);
		return strobe && (addr == target);
	endfunction

	// Address decode of the single-cycle request strobes
	assign wr_flags = strobe_at(req_in.wr, req_in.addr, ADDR_FLAGS);
	assign wr_status = strobe_at(req_in.wr, req_in.addr, ADDR_STATUS);
	assign rd_flags = strobe_at(req_in.rd, req_in.addr, ADDR_FLAGS);
	assign rd_status = strobe_at(req_in.rd, req_in.addr, ADDR_STATUS);

	// Detector levels become flag events; write data bits become clears
	assign events = fault_events(cond_in);
	assign clear_vec = wr_flags ? req_in.wdata[FLAG_W-1:0] : FLAG_RESET;

	// Sticky flag storage with enable gating
	fault_flag_bank u_bank (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.set_in(events),
		.enable_in(diag_enable_in),
		.clear_in(clear_vec),
		.flags_out(flags_raw),
		.visible_out(visible)
	);

	// Readback word assembly
	status_word_pack u_pack (
		.alarm_pin_n_in(alarm_pin_n_in),
		.digital_fault_summary_in(digital_fault_summary_in),
		.visible_in(visible),
		.adc_status_in(adc_status_in),
		.flags_word_out(flags_word),
		.status_word_out(status_word)
	);

	// Read answer, summary and read-only write report
	// A read in the same cycle as a clear returns the pre-clear flags
	always_comb begin
		resp_nxt.valid = req_in.rd;
		resp_nxt.hit = rd_flags || rd_status;
		if (rd_flags) begin
			resp_nxt.data = flags_word;
		end else if (rd_status) begin
			resp_nxt.data = status_word;
		end else begin
			resp_nxt.data = WORD_ZERO;
		end
		summary_nxt = |visible;
		ro_write_nxt = wr_status; // Status is read only; write is reported, not stored
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			resp_r <= '0;
			summary_r <= 1'b0;
			ro_write_r <= 1'b0;
		end else begin
			resp_r <= resp_nxt;
			summary_r <= summary_nxt;
			ro_write_r <= ro_write_nxt;
		end
	end

	assign resp_out = resp_r;
	assign analog_fault_summary_out = summary_r;
	assign ro_write_out = ro_write_r;

	// Checks on the register behaviour
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	// Flags are empty right after reset
	reset_flags_clear_a: assert property ($rose(rst_n_in) |-> flags_raw == FLAG_RESET)
		else $error("flags not cleared by reset");

	// Read of the flag register carries its own address
	flags_address_a: assert property (rd_flags |=> resp_out.valid && resp_out.hit
		&& resp_out.data[ADDR_HI:ADDR_LO] == ADDR_FLAGS)
		else $error("flag readback address wrong");

	// Empty flags with idle alarm read back as the reset word
	flags_reset_word_a: assert property (rd_flags && flags_raw == FLAG_RESET && alarm_pin_n_in
		|=> resp_out.data == RST_FLAGS_WORD)
		else $error("flag readback not equal to reset word");

	// Alarm bit is the inverse of the pin at the read
	alarm_inverted_a: assert property ((rd_flags || rd_status)
		|=> resp_out.data[POS_ALARM] == !$past(alarm_pin_n_in))
		else $error("alarm bit not inverted pin level");

	// Writing 1 with no live event empties the bit
	write_one_clear_a: assert property (wr_flags
		|=> (flags_raw & $past(clear_vec) & ~$past(events & diag_enable_in)) == FLAG_RESET)
		else $error("write of one did not clear flag");

	// A flag not cleared stays set, whatever the condition does
	sticky_hold_a: assert property (1'b1 |=> (($past(flags_raw) & ~$past(clear_vec)) & ~flags_raw) == FLAG_RESET)
		else $error("flag dropped without a clear");

	// Live enabled event wins over a same-cycle clear
	set_wins_a: assert property (1'b1
		|=> (($past(events & diag_enable_in & FLAG_IMPL_MASK)) & ~flags_raw) == FLAG_RESET)
		else $error("enabled event lost");

	// Disabled diagnostics return zero
	disabled_zero_a: assert property (rd_flags
		|=> (resp_out.data[FLAG_W-1:0] & ~$past(diag_enable_in)) == FLAG_RESET)
		else $error("disabled flag read nonzero");

	// Reserved bits never read back set
	reserved_zero_a: assert property (rd_flags ##1 1'b1 |-> resp_out.data[15:14] == 2'h0
		&& resp_out.data[12] == 1'b0 && resp_out.data[10] == 1'b0 && resp_out.data[8] == 1'b0)
		else $error("reserved bit read nonzero");

	// Reserved bits never hold state
	reserved_store_a: assert property (1'b1 |=> (flags_raw & ~FLAG_IMPL_MASK) == FLAG_RESET)
		else $error("reserved bit stored");

	// Summary bit in status tracks the visible flags
	status_summary_a: assert property (rd_status
		|=> resp_out.data[POS_ANA_SUM] == (|$past(visible)))
		else $error("status analog summary wrong");

	// Summary output follows the flags one cycle late
	summary_out_a: assert property (1'b1 |=> analog_fault_summary_out == (|$past(visible)))
		else $error("summary output wrong");

	// Status word carries the neighbouring status fields
	status_fields_a: assert property (rd_status |=> resp_out.hit
		&& resp_out.data[ADC_DATA_HI:0] == $past(adc_status_in.data)
		&& resp_out.data[ADC_CH_HI:ADC_CH_LO] == $past(adc_status_in.ch)
		&& resp_out.data[POS_WDT] == $past(adc_status_in.wdt)
		&& resp_out.data[POS_ADC_BUSY] == $past(adc_status_in.busy)
		&& resp_out.data[POS_DIG_SUM] == $past(digital_fault_summary_in))
		else $error("status fields wrong");

	// Status reset word when only the digital summary is high
	status_reset_word_a: assert property (rd_status && visible == FLAG_RESET && alarm_pin_n_in
		&& digital_fault_summary_in && adc_status_in == '0 |=> resp_out.data == RST_STATUS_WORD)
		else $error("status readback not equal to reset word");

	// Writes to the status register are reported and change nothing
	status_write_a: assert property (wr_status && !wr_flags |=> ro_write_out)
		else $error("read-only write not reported");

	// Each detector reaches its own bit when enabled
	vout_ovr_a: assert property (cond_in.vout_ovr && diag_enable_in[POS_VOUT_OV] |=> flags_raw[POS_VOUT_OV])
		else $error("output overvoltage flag missed");
	dcdc_short_a: assert property (cond_in.dcdc_short && diag_enable_in[POS_DCDC_SC]
		|=> flags_raw[POS_DCDC_SC])
		else $error("converter short flag missed");
	dcdc_reg_a: assert property (cond_in.dcdc_regulation && diag_enable_in[POS_DCDC_PWR]
		|=> flags_raw[POS_DCDC_PWR])
		else $error("converter regulation flag missed");
	iout_open_a: assert property ((cond_in.iout_open || cond_in.iout_headroom)
		&& diag_enable_in[POS_IOUT_OPEN] |=> flags_raw[POS_IOUT_OPEN])
		else $error("current open flag missed");
	vout_short_a: assert property (cond_in.vout_short && diag_enable_in[POS_VOUT_SC]
		|=> flags_raw[POS_VOUT_SC])
		else $error("voltage short flag missed");
	dcdc_temp_a: assert property (cond_in.dcdc_overtemp && diag_enable_in[POS_DCDC_TEMP]
		|=> flags_raw[POS_DCDC_TEMP])
		else $error("converter die temperature flag missed");
	main_temp_a: assert property (cond_in.main_overtemp && diag_enable_in[POS_MAIN_TEMP]
		|=> flags_raw[POS_MAIN_TEMP])
		else $error("main die temperature flag missed");
	reference_output_node_a: assert property ((cond_in.reference_output_node_window || cond_in.reference_output_node_ilimit)
		&& diag_enable_in[POS_REFERENCE_OUTPUT_NODE] |=> flags_raw[POS_REFERENCE_OUTPUT_NODE])
		else $error("reference output flag missed");
	reference_input_node_a: assert property (cond_in.reference_input_node_window && diag_enable_in[POS_REFERENCE_INPUT_NODE]
		|=> flags_raw[POS_REFERENCE_INPUT_NODE])
		else $error("reference input flag missed");
	intavcc_a: assert property (cond_in.intavcc_window && diag_enable_in[POS_INTAVCC]
		|=> flags_raw[POS_INTAVCC])
		else $error("internal supply flag missed");
	ldo_node_a: assert property ((cond_in.ldo_window || cond_in.ldo_ilimit)
		&& diag_enable_in[POS_LDO] |=> flags_raw[POS_LDO])
		else $error("regulator node flag missed");

	// Disabled detector cannot raise a clear flag
	disabled_no_set_a: assert property (1'b1
		|=> ((flags_raw & ~$past(flags_raw)) & ~$past(diag_enable_in)) == FLAG_RESET)
		else $error("disabled detector set a flag");

	// Every read gets an answer on the next cycle
	read_answer_a: assert property (req_in.rd
		|=> resp_out.valid)
		else $error("read not answered");

	// No answer and no hit without a read
	no_stray_answer_a: assert property (!req_in.rd
		|=> !resp_out.valid && !resp_out.hit)
		else $error("answer without a read");

	// Reads of other addresses miss and return zero
	unmapped_read_a: assert property (req_in.rd && !rd_flags && !rd_status
		|=> !resp_out.hit && resp_out.data == WORD_ZERO)
		else $error("unmapped read not zero");

	// Flag field is the stored flags masked by their enables
	flags_field_a: assert property (rd_flags
		|=> resp_out.data[FLAG_W-1:0] == ($past(flags_raw) & $past(diag_enable_in) & FLAG_IMPL_MASK))
		else $error("flag field wrong");

	// Zero bits of a flag write leave their flags alone
	write_zero_keep_a: assert property (wr_flags
		|=> (($past(flags_raw) & ~$past(req_in.wdata[FLAG_W-1:0])) & ~flags_raw) == FLAG_RESET)
		else $error("zero write dropped a flag");

	// Writes elsewhere never clear a flag
	other_write_keep_a: assert property (req_in.wr && !wr_flags
		|=> ($past(flags_raw) & ~flags_raw) == FLAG_RESET)
		else $error("foreign write cleared a flag");

	// A write to the read-only status word leaves the flags alone
	status_write_keep_a: assert property (wr_status
		|=> ($past(flags_raw) & ~flags_raw) == FLAG_RESET)
		else $error("status write cleared a flag");

	// A flag only rises on a live event
	rise_needs_event_a: assert property (1'b1
		|=> ((flags_raw & ~$past(flags_raw)) & ~$past(events)) == FLAG_RESET)
		else $error("flag rose without an event");

	// Read-only write report only follows a status write
	ro_write_quiet_a: assert property (!wr_status
		|=> !ro_write_out)
		else $error("stray read-only write report");

	// Outputs start quiet when reset lets go
	reset_outputs_a: assert property ($rose(rst_n_in)
		|-> !resp_out.valid && !analog_fault_summary_out && !ro_write_out)
		else $error("outputs not quiet after reset");

	// No visible flag means no summary a cycle later
	summary_clear_a: assert property (visible == FLAG_RESET
		|=> !analog_fault_summary_out)
		else $error("summary set without a visible flag");

	// Status read answers with a hit and the inverted alarm
	status_alarm_a: assert property (rd_status
		|=> resp_out.hit && resp_out.data[POS_ALARM] == !$past(alarm_pin_n_in))
		else $error("status alarm bit wrong");

	// A read right after a clear sees the cleared bits low unless refreshed
	clear_then_read_a: assert property (wr_flags && !req_in.rd ##1 rd_flags
		|=> (resp_out.data[FLAG_W-1:0] & $past(clear_vec, 2)
		& ~$past(events & diag_enable_in, 2)) == FLAG_RESET)
		else $error("cleared flag read back set");

	// A refreshed flag whose condition is still present stays set
	refresh_keeps_a: assert property (wr_flags
		|=> (flags_raw & $past(clear_vec & events & diag_enable_in & FLAG_IMPL_MASK))
		== $past(clear_vec & events & diag_enable_in & FLAG_IMPL_MASK))
		else $error("refreshed flag lost");

	// An enabled main die event reaches the summary two cycles on
	summary_latency_a: assert property (cond_in.main_overtemp && diag_enable_in[POS_MAIN_TEMP]
		##1 diag_enable_in[POS_MAIN_TEMP] |=> analog_fault_summary_out)
		else $error("summary late after event");

	// Write data on reserved positions never reaches storage
	high_write_ignored_a: assert property (wr_flags
		|=> (flags_raw & ~FLAG_IMPL_MASK) == FLAG_RESET)
		else $error("reserved write bit stored");

	// A disabled diagnostic hides its flag on readback
	disabled_hidden_a: assert property (rd_flags && !diag_enable_in[POS_VOUT_OV]
		|=> !resp_out.data[POS_VOUT_OV])
		else $error("disabled flag visible");

	// Main scenarios
	clear_set_flag_c: cover property (flags_raw != FLAG_RESET && wr_flags ##1 flags_raw == FLAG_RESET);
	collision_c: cover property (wr_flags && (clear_vec & events & diag_enable_in) != FLAG_RESET);
	read_both_c: cover property (rd_flags ##1 rd_status ##1 resp_out.hit);
	alarm_read_c: cover property (rd_flags && !alarm_pin_n_in);
	disabled_hide_c: cover property (rd_flags && (flags_raw & ~diag_enable_in) != FLAG_RESET);

endmodule

`default_nettype wire

// [design/fault_regs_pkg.sv]
`default_nettype none

package fault_regs_pkg;

	// Register addresses and word layout
	localparam logic [4:0] ADDR_FLAGS = 5'h15;
	localparam logic [4:0] ADDR_STATUS = 5'h16;
	localparam int WORD_W = 22;
	localparam int FLAG_W = 14;

	// Alarm field of both words, address field of the flag word
	localparam int POS_ALARM = 21;
	localparam int ADDR_HI = 20;
	localparam int ADDR_LO = 16;

	// Fault flag positions
	localparam int POS_VOUT_OV = 13;
	localparam int POS_DCDC_SC = 11;
	localparam int POS_DCDC_PWR = 9;
	localparam int POS_IOUT_OPEN = 7;
	localparam int POS_VOUT_SC = 6;
	localparam int POS_DCDC_TEMP = 5;
	localparam int POS_MAIN_TEMP = 4;
	localparam int POS_REFERENCE_OUTPUT_NODE = 3;
	localparam int POS_REFERENCE_INPUT_NODE = 2;
	localparam int POS_INTAVCC = 1;
	localparam int POS_LDO = 0;

	// Combined status positions
	localparam int POS_DIG_SUM = 20;
	localparam int POS_ANA_SUM = 19;
	localparam int POS_WDT = 18;
	localparam int POS_ADC_BUSY = 17;
	localparam int ADC_CH_HI = 16;
	localparam int ADC_CH_LO = 12;
	localparam int ADC_DATA_HI = 11;

	// Implemented flags; bits 15:14, 12, 10 and 8 hold no state
	localparam logic [FLAG_W-1:0] FLAG_IMPL_MASK = 14'h2aff;
	localparam logic [FLAG_W-1:0] FLAG_RESET = 14'h0000;
	localparam logic [WORD_W-1:0] RST_FLAGS_WORD = 22'h150000;
	localparam logic [WORD_W-1:0] RST_STATUS_WORD = 22'h100000;
	localparam logic [WORD_W-1:0] WORD_ZERO = 22'h000000;

	// Read answer arrives this many cycles after the request
	localparam int READ_LATENCY = 1;

	typedef logic [FLAG_W-1:0] flag_vec_t;
	typedef logic [WORD_W-1:0] word_t;

	// Raw detector outputs, level sensitive
	typedef struct packed {
		logic vout_ovr;
		logic dcdc_short;
		logic dcdc_regulation;
		logic iout_open;
		logic iout_headroom;
		logic vout_short;
		logic dcdc_overtemp;
		logic main_overtemp;
		logic reference_output_node_window;
		logic reference_output_node_ilimit;
		logic reference_input_node_window;
		logic intavcc_window;
		logic ldo_window;
		logic ldo_ilimit;
	} fault_cond_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		word_t wdata;
	} reg_req_s;

	typedef struct packed {
		logic valid;
		logic hit;
		word_t data;
	} reg_resp_s;

	typedef struct packed {
		logic wdt;
		logic busy;
		logic [4:0] ch;
		logic [11:0] data;
	} adc_status_s;

	// Map detector conditions onto flag positions
	function automatic flag_vec_t fault_events(input fault_cond_s c);
		flag_vec_t ev;
		ev = FLAG_RESET;
		ev[POS_VOUT_OV] = c.vout_ovr;
		ev[POS_DCDC_SC] = c.dcdc_short;
		ev[POS_DCDC_PWR] = c.dcdc_regulation;
		ev[POS_IOUT_OPEN] = c.iout_open | c.iout_headroom;
		ev[POS_VOUT_SC] = c.vout_short;
		ev[POS_DCDC_TEMP] = c.dcdc_overtemp;
		ev[POS_MAIN_TEMP] = c.main_overtemp;
		ev[POS_REFERENCE_OUTPUT_NODE] = c.reference_output_node_window | c.reference_output_node_ilimit;
		ev[POS_REFERENCE_INPUT_NODE] = c.reference_input_node_window;
		ev[POS_INTAVCC] = c.intavcc_window;
		ev[POS_LDO] = c.ldo_window | c.ldo_ilimit;
		return ev;
	endfunction

endpackage

`default_nettype wire

// [design/fault_flag_bank.sv]
`timescale 1ns/1ps
`default_nettype none

module fault_flag_bank (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Events and host clears
	input wire fault_regs_pkg::flag_vec_t set_in,
	input wire fault_regs_pkg::flag_vec_t enable_in,
	input wire fault_regs_pkg::flag_vec_t clear_in,
	// Stored and visible flags
	output fault_regs_pkg::flag_vec_t flags_out,
	output fault_regs_pkg::flag_vec_t visible_out
);
	import fault_regs_pkg::*;

	flag_vec_t flags_r;
	flag_vec_t flags_nxt;

	// Sticky flags; a live enabled event beats a same-cycle clear so nothing is lost
	always_comb begin
		flags_nxt = (flags_r & ~clear_in) | (set_in & enable_in & FLAG_IMPL_MASK);
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			flags_r <= FLAG_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// Disabled diagnostics read as zero even if a stale flag is stored
	assign flags_out = flags_r;
	assign visible_out = flags_r & enable_in & FLAG_IMPL_MASK;

endmodule

`default_nettype wire

// [design/status_word_pack.sv]
`timescale 1ns/1ps
`default_nettype none

module status_word_pack (
	// Sources
	input wire logic alarm_pin_n_in,
	input wire logic digital_fault_summary_in,
	input wire fault_regs_pkg::flag_vec_t visible_in,
	input wire fault_regs_pkg::adc_status_s adc_status_in,
	// Packed readback words
	output fault_regs_pkg::word_t flags_word_out,
	output fault_regs_pkg::word_t status_word_out
);
	import fault_regs_pkg::*;

	// Both words carry the inverted alarm level as seen right now
	always_comb begin
		flags_word_out = WORD_ZERO;
		flags_word_out[POS_ALARM] = ~alarm_pin_n_in;
		flags_word_out[ADDR_HI:ADDR_LO] = ADDR_FLAGS;
		flags_word_out[FLAG_W-1:0] = visible_in;
		status_word_out = WORD_ZERO;
		status_word_out[POS_ALARM] = ~alarm_pin_n_in;
		status_word_out[POS_DIG_SUM] = digital_fault_summary_in;
		status_word_out[POS_ANA_SUM] = |visible_in;
		status_word_out[POS_WDT] = adc_status_in.wdt;
		status_word_out[POS_ADC_BUSY] = adc_status_in.busy;
		status_word_out[ADC_CH_HI:ADC_CH_LO] = adc_status_in.ch;
		status_word_out[ADC_DATA_HI:0] = adc_status_in.data;
	end

endmodule

`default_nettype wire

// [dv/host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module host_model (
	// Clock
	input wire logic mclk_in,
	// Requests towards the register block
	output var fault_regs_pkg::reg_req_s req_out
);
	import fault_regs_pkg::*;

	// Strobes start low so nothing is taken before reset ends
	initial req_out = '0;

	// One access per call, held across the taking edge until the next access or idle replaces it
	task automatic access(input logic wr, input logic rd, input logic [4:0] addr, input word_t wdata);
		req_out.wr = wr;
		req_out.rd = rd;
		req_out.addr = addr;
		req_out.wdata = wdata;
		@(posedge mclk_in);
		#1;
	endtask

	// Strobes drop; qualifiers flip so a stale address never looks meaningful
	task automatic idle;
		req_out.wr = 1'b0;
		req_out.rd = 1'b0;
		req_out.addr = ~req_out.addr;
		req_out.wdata = ~req_out.wdata;
	endtask
endmodule

`default_nettype wire

// [dv/test_analog_fault_flag_register.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end

module test_analog_fault_flag_register;
	import fault_regs_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	reg_req_s req;
	reg_resp_s resp;
	fault_cond_s cond = '0;
	flag_vec_t en = '1;
	logic alarm_n = 1'b1;
	adc_status_s adc = '0;
	logic dig = 1'b1;
	logic asum, ro_wr;
	flag_vec_t mflags = '0;
	flag_vec_t vis, clr;
	logic sum_exp = 1'b0;
	logic ro_exp = 1'b0;
	logic [22:0] expq[$];
	logic [22:0] e;
	logic [31:0] r;
	logic [4:0] a;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	int i;
	integer seed = 32'hc382b35c;

	host_model u_host (.mclk_in(mclk_in), .req_out(req));

	analog_fault_regs u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(req), .resp_out(resp),
		.cond_in(cond), .diag_enable_in(en), .alarm_pin_n_in(alarm_n), .adc_status_in(adc),
		.digital_fault_summary_in(dig), .analog_fault_summary_out(asum), .ro_write_out(ro_wr));

	// 100 MHz clock
	always #5 mclk_in = ~mclk_in;

	// Detector to flag mapping, written out independently of the design
	function automatic flag_vec_t ev_of(fault_cond_s c);
		ev_of = '0;
		ev_of[13] = c.vout_ovr;
		ev_of[11] = c.dcdc_short;
		ev_of[9] = c.dcdc_regulation;
		ev_of[7] = c.iout_open | c.iout_headroom;
		ev_of[6] = c.vout_short;
		ev_of[5] = c.dcdc_overtemp;
		ev_of[4] = c.main_overtemp;
		ev_of[3] = c.reference_output_node_window | c.reference_output_node_ilimit;
		ev_of[2] = c.reference_input_node_window;
		ev_of[1] = c.intavcc_window;
		ev_of[0] = c.ldo_window | c.ldo_ilimit;
	endfunction

	// Reference flags: sticky, set beats clear, enable hides without erasing
	assign vis = mflags & en & FLAG_IMPL_MASK;
	always @(posedge mclk_in) begin
		clr = (req.wr && req.addr == ADDR_FLAGS) ? req.wdata[FLAG_W-1:0] : '0;
		if (!rst_n_in) begin
			mflags <= '0;
			sum_exp <= 1'b0;
			ro_exp <= 1'b0;
		end else begin
			mflags <= ((mflags & ~clr) | (ev_of(cond) & en)) & FLAG_IMPL_MASK;
			sum_exp <= |vis;
			ro_exp <= req.wr && req.addr == ADDR_STATUS;
		end
	end

	// Expected readback of an address as sampled in the request cycle
	function automatic word_t exp_rd(logic [4:0] ad);
		flag_vec_t v;
		// Enable may change in this very time step, before the vis net catches up
		v = mflags & en & FLAG_IMPL_MASK;
		if (ad == ADDR_FLAGS)
			return {~alarm_n, ADDR_FLAGS, 2'b00, v};
		if (ad == ADDR_STATUS)
			return {~alarm_n, dig, |v, adc.wdt, adc.busy, adc.ch, adc.data};
		return WORD_ZERO;
	endfunction

	// Note the expected answer, then hand the access to the host model
	task automatic op(input logic wr, input logic rd, input logic [4:0] ad, input word_t wd);
		if (rd)
			expq.push_back({ad == ADDR_FLAGS || ad == ADDR_STATUS, exp_rd(ad)});
		u_host.access(wr, rd, ad, wd);
	endtask

	task automatic tick;
		@(posedge mclk_in);
		#1;
	endtask

	task automatic pause;
		u_host.idle();
		tick();
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Scoreboard on the falling edge, where registered outputs have settled
	always @(negedge mclk_in) begin
		if (resp.valid === 1'b1) begin
			if (expq.size() == 0) begin
				`CHK("unrequested answer", 1'b0, 1'b1)
			end else begin
				e = expq.pop_front();
				`CHK("read word", e, {resp.hit, resp.data})
			end
		end
		`CHK("analog summary", sum_exp, asum)
		`CHK("read-only write pulse", ro_exp, ro_wr)
	end

	// Hang guard, well above the roughly 520 cycles the run needs
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	initial begin
		repeat (6) @(posedge mclk_in);
		#1 rst_n_in = 1'b1;
		op(1'b0, 1'b1, ADDR_FLAGS, WORD_ZERO);
		op(1'b0, 1'b1, ADDR_STATUS, WORD_ZERO);
		pause();
		// Each detector alone: latch, survive, ignore a 0 write, clear on a 1
		for (i = 0; i < FLAG_W; i++) begin
			cond = fault_cond_s'(14'h0001 << i);
			tick();
			cond = '0;
			op(1'b0, 1'b1, ADDR_FLAGS, WORD_ZERO);
			op(1'b1, 1'b1, ADDR_FLAGS, WORD_ZERO);
			op(1'b0, 1'b1, ADDR_FLAGS, WORD_ZERO);
			op(1'b1, 1'b0, ADDR_FLAGS, 22'h3fffff);
			op(1'b0, 1'b1, ADDR_FLAGS, WORD_ZERO);
			pause();
		end
		// Disabled diagnostics read zero, yet the stored state returns
		cond = fault_cond_s'(14'h3fff);
		tick();
		cond = '0;
		en = '0;
		op(1'b0, 1'b1, ADDR_FLAGS, WORD_ZERO);
		en = '1;
		op(1'b0, 1'b1, ADDR_FLAGS, WORD_ZERO);
		op(1'b1, 1'b0, ADDR_FLAGS, 22'h3fffff);
		// Alarm low, status sources, writes to read-only and unmapped places
		alarm_n = 1'b0;
		dig = 1'b0;
		adc = adc_status_s'(19'($random(seed)));
		op(1'b1, 1'b1, ADDR_STATUS, 22'h3fffff);
		op(1'b0, 1'b1, 5'h17, WORD_ZERO);
		op(1'b1, 1'b0, 5'h17, 22'h3fffff);
		pause();
		// Random back-to-back traffic against sparse random faults
		repeat (400) begin
			cond = fault_cond_s'(14'($random(seed) & $random(seed) & $random(seed)));
			alarm_n = 1'($random(seed));
			dig = 1'($random(seed));
			en = 14'($random(seed) | $random(seed));
			adc = adc_status_s'(19'($random(seed)));
			r = $random(seed);
			a = (r[4:2] == 3'h0) ? 5'($random(seed)) : ADDR_FLAGS + {4'h0, r[5]};
			op(r[0], r[1], a, 22'($random(seed)));
		end
		pause();
		// Reset in mid-run wipes every flag
		alarm_n = 1'b1;
		en = '1;
		cond = fault_cond_s'(14'h3fff);
		tick();
		cond = '0;
		rst_n_in = 1'b0;
		tick();
		tick();
		rst_n_in = 1'b1;
		op(1'b0, 1'b1, ADDR_FLAGS, WORD_ZERO);
		pause();
		tick();
		tick();
		`CHK("answers outstanding", 0, expq.size())
		print_verdict();
	end
endmodule

`default_nettype wire
